// ==== rtl/rjd_pkg.sv ====
package rjd_pkg;
	localparam logic [7:0] ADDR_CFG = 8'h27;
	localparam logic [7:0] ADDR_IEN = 8'h34;
	localparam logic [7:0] ADDR_MEAS = 8'h39;
	localparam logic [7:0] ADDR_ISTAT = 8'h3A;
	localparam logic [7:0] ADDR_LCODE = 8'h3B;
	localparam logic [7:0] ADDR_CNTL = 8'h3C;
	localparam logic [7:0] ADDR_CNTH = 8'h3D;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] IEN_RESET = 8'h00;
	localparam logic [7:0] LCODE_RESET = 8'h00;
	// Config register bit positions
	localparam int CFG_ENABLE = 0;
	localparam int CFG_DEPTH_LO = 1;
	localparam int CFG_CORNER = 3;
	localparam int CFG_LIMIT = 4;
	localparam int CFG_MEASURE = 5;
	// Status and enable bit positions
	localparam int ST_SLIP = 0;
	localparam int ST_VIOL = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_OVF = 3;
	// Line code register bit positions
	localparam int LC_E1 = 0;
	localparam int LC_CODE = 1;
	localparam int LC_STD = 2;
	localparam int LC_CNTSEL_LO = 3;
	localparam int LC_MODE = 5;
	localparam int LC_TRF = 6;
	localparam logic [1:0] COUNT_SEL_ON = 2'h1;
	// Zero-run limits
	localparam int ZR_AMI_ANSI = 15;
	localparam int ZR_AMI_FCC = 80;
	localparam int ZR_B8ZS = 7;
	localparam int ZR_HDB3 = 3;
	// Depth codes, limits in bits
	localparam logic [7:0] DEPTH_32 = 8'h20;
	localparam logic [7:0] DEPTH_64 = 8'h40;
	localparam logic [7:0] DEPTH_128 = 8'h80;
	localparam logic [7:0] MARGIN_32 = 8'h02;
	localparam logic [7:0] MARGIN_64 = 8'h03;
	localparam logic [7:0] MARGIN_128 = 8'h04;
	// Corner frequency in milli-hertz
	localparam int CF_T1_WIDE_MHZ = 5000;
	localparam int CF_T1_NARROW_MHZ = 1260;
	localparam int CF_E1_WIDE_MHZ = 6770;
	localparam int CF_E1_NARROW_MHZ = 870;
	localparam int CLK_MHZ = 200;
	localparam int SECOND_NS = 1000000000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	typedef struct packed {
		logic valid;
		logic pos;
		logic neg;
	} rjd_sym_t;
endpackage

// ==== rtl/rjd_decoder.sv ====
`timescale 1ns/1ps
module rjd_decoder #(
	parameter int SECOND_CYC = rjd_pkg::SECOND_CYCLES,
	parameter int PHASE_W = 24
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic lineSymValid,
	input wire logic linePos,
	input wire logic lineNeg,
	output logic dataValid,
	output logic dataOut,
	output logic bipolarViolation,
	output logic codeViolation,
	output logic excessiveZero,
	output logic int_n
);
	// ============================================================
	// Registers
	logic [7:0] cfg_q, ien_q, lcode_q, istat_q, meas_q, cntL_q, cntH_q;
	logic [7:0] rdata_q;
	wire atten_enable = cfg_q[rjd_pkg::CFG_ENABLE];
	wire [1:0] atten_fifo_depth_sel = cfg_q[rjd_pkg::CFG_DEPTH_LO +: 2];
	wire atten_corner_sel = cfg_q[rjd_pkg::CFG_CORNER];
	wire atten_rate_limit_en = cfg_q[rjd_pkg::CFG_LIMIT];
	wire pointer_measure_mode = cfg_q[rjd_pkg::CFG_MEASURE];
	wire e1Mode = lcode_q[rjd_pkg::LC_E1];
	wire rx_line_code_sel = lcode_q[rjd_pkg::LC_CODE];
	wire zero_run_standard_sel = lcode_q[rjd_pkg::LC_STD];
	wire [1:0] zero_run_count_sel = lcode_q[rjd_pkg::LC_CNTSEL_LO +: 2];
	wire count_report_mode = lcode_q[rjd_pkg::LC_MODE];
	wire count_transfer_trigger = lcode_q[rjd_pkg::LC_TRF];
	wire wrCfg = regWr && regAddr == rjd_pkg::ADDR_CFG;
	wire wrIen = regWr && regAddr == rjd_pkg::ADDR_IEN;
	wire wrLc = regWr && regAddr == rjd_pkg::ADDR_LCODE;
	wire wrStat = regWr && regAddr == rjd_pkg::ADDR_ISTAT;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= rjd_pkg::CFG_RESET;
			ien_q <= rjd_pkg::IEN_RESET;
			lcode_q <= rjd_pkg::LCODE_RESET;
		end else begin
			if (wrCfg) cfg_q <= regWdata;
			if (wrIen) ien_q <= regWdata;
			if (wrLc) lcode_q <= regWdata;
		end
	end
	// Unmapped addresses read zero
	wire [7:0] rdMux =
		(regAddr == rjd_pkg::ADDR_CFG) ? cfg_q :
		(regAddr == rjd_pkg::ADDR_IEN) ? ien_q :
		(regAddr == rjd_pkg::ADDR_MEAS) ? meas_q :
		(regAddr == rjd_pkg::ADDR_ISTAT) ? istat_q :
		(regAddr == rjd_pkg::ADDR_LCODE) ? lcode_q :
		(regAddr == rjd_pkg::ADDR_CNTL) ? cntL_q :
		(regAddr == rjd_pkg::ADDR_CNTH) ? cntH_q : 8'h00;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) rdata_q <= 8'h00;
		else rdata_q <= regRd ? rdMux : 8'h00;
	end
	assign regRdata = rdata_q;
	// ============================================================
	// Input synchroniser: three stages, change accepted when 2nd and 3rd agree
	logic [2:0] s1_q, s2_q, s3_q, sym_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
			sym_q <= 3'h0;
		end else begin
			s1_q <= {lineSymValid, linePos, lineNeg};
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) sym_q <= s3_q;
		end
	end
	// A symbol is a rising edge of the valid strobe
	logic symValPrev_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) symValPrev_q <= 1'b0;
		else symValPrev_q <= sym_q[2];
	end
	rjd_pkg::rjd_sym_t inSym;
	assign inSym = '{valid: sym_q[2] && !symValPrev_q, pos: sym_q[1], neg: sym_q[0]};
	// ============================================================
	// Jitter attenuator: array FIFO of symbols, read by a DPLL tick
	// Symbols are stored as pos/neg pairs so the decoder downstream still sees polarity.
	localparam int MAXD = 128;
	logic [1:0] fifoMem [MAXD];
	logic [6:0] wrPtr_q, rdPtr_q;
	logic [7:0] fill_q;
	wire [7:0] depth = (atten_fifo_depth_sel == 2'h0) ? rjd_pkg::DEPTH_32 :
		(atten_fifo_depth_sel == 2'h1) ? rjd_pkg::DEPTH_64 : rjd_pkg::DEPTH_128;
	wire [7:0] margin = (atten_fifo_depth_sel == 2'h0) ? rjd_pkg::MARGIN_32 :
		(atten_fifo_depth_sel == 2'h1) ? rjd_pkg::MARGIN_64 : rjd_pkg::MARGIN_128;
	wire [6:0] ptrMask = 7'(depth - 8'h01);
	// DPLL: phase accumulator whose step tracks the write rate with a loop gain set by corner
	logic [PHASE_W-1:0] phase_q, step_q;
	logic [PHASE_W-1:0] sinceWr_q;
	logic started_q;
	wire [3:0] gainShift = e1Mode ? (atten_corner_sel ? 4'h9 : 4'h6) : (atten_corner_sel ? 4'h8 : 4'h6);
	wire nearFull = fill_q >= depth - margin;
	wire nearEmpty = fill_q <= margin;
	wire [PHASE_W-1:0] limStep = (atten_rate_limit_en && nearFull) ? step_q + (step_q >> 3) :
		(atten_rate_limit_en && nearEmpty) ? step_q - (step_q >> 3) : step_q;
	wire [PHASE_W:0] phaseSum = {1'b0, phase_q} + {1'b0, limStep};
	wire rdTick = started_q && phaseSum[PHASE_W];
	wire fifoWr = atten_enable && inSym.valid;
	wire overflow = fifoWr && !rdTick && fill_q == depth;
	wire underflow = rdTick && !fifoWr && fill_q == 8'h00;
	wire doWr = fifoWr && !overflow;
	wire doRd = rdTick && !underflow;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_q <= 7'h00;
			rdPtr_q <= 7'h00;
			fill_q <= 8'h00;
			phase_q <= '0;
			step_q <= '0;
			sinceWr_q <= '0;
			started_q <= 1'b0;
		end else if (!atten_enable) begin
			wrPtr_q <= 7'h00;
			rdPtr_q <= 7'h00;
			fill_q <= 8'h00;
			started_q <= 1'b0;
			phase_q <= '0;
		end else begin
			if (doWr) wrPtr_q <= (wrPtr_q + 7'h01) & ptrMask;
			if (doRd) rdPtr_q <= (rdPtr_q + 7'h01) & ptrMask;
			fill_q <= 8'(fill_q + {7'h00, doWr} - {7'h00, doRd});
			// Reading starts at half depth so latency is half the FIFO
			if (fill_q >= (depth >> 1)) started_q <= 1'b1;
			phase_q <= phaseSum[PHASE_W-1:0];
			sinceWr_q <= fifoWr ? '0 : sinceWr_q + 1'b1;
			// Low corner means small gain: slow, smooth tracking of the write period
			if (fifoWr && sinceWr_q != '0)
				step_q <= step_q - (step_q >> gainShift) + ((~'0 / sinceWr_q) >> gainShift);
		end
	end
	always_ff @(posedge clk) begin
		if (doWr) fifoMem[wrPtr_q] <= {inSym.pos, inSym.neg};
	end
	// Bypass path takes the synchronised symbol directly
	rjd_pkg::rjd_sym_t decSym;
	assign decSym = atten_enable ? '{valid: doRd, pos: fifoMem[rdPtr_q][1], neg: fifoMem[rdPtr_q][0]}
		: inSym;
	wire [6:0] curDist = 7'(fill_q);
	// ============================================================
	// Line decoder
	logic lastPol_q, seenPulse_q;
	logic [6:0] zeros_q;
	logic [7:0] hist_q;
	wire pulse = decSym.pos ^ decSym.neg;
	wire pol = decSym.pos;
	wire sameAsLast = decSym.valid && pulse && seenPulse_q && pol == lastPol_q;
	wire useCode = rx_line_code_sel;
	// Substitution pulses: B8ZS 000VB0VB, HDB3 000V / B00V; violations there are legal
	// Second violation of 000VB0VB follows one zero after V then B; history pins it to the pattern
	wire b8zsSub = !e1Mode && useCode && (zeros_q == 7'h03 || (zeros_q == 7'h01 && hist_q[5:0] == 6'h06));
	wire hdb3Sub = e1Mode && useCode && (zeros_q == 7'h03 || zeros_q == 7'h02);
	wire bipolar_violation = sameAsLast && !useCode;
	wire cv = sameAsLast && useCode && !b8zsSub && !hdb3Sub;
	wire [6:0] zrLimit = !useCode ? (zero_run_standard_sel ? 7'(rjd_pkg::ZR_AMI_FCC) : 7'(rjd_pkg::ZR_AMI_ANSI)) :
		(e1Mode ? 7'(rjd_pkg::ZR_HDB3) : 7'(rjd_pkg::ZR_B8ZS));
	wire excessive_zero = decSym.valid && !pulse && zeros_q == zrLimit;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lastPol_q <= 1'b0;
			seenPulse_q <= 1'b0;
			zeros_q <= 7'h00;
			hist_q <= 8'h00;
		end else if (decSym.valid) begin
			if (pulse) begin
				lastPol_q <= pol;
				seenPulse_q <= 1'b1;
				zeros_q <= 7'h00;
			end else if (zeros_q != 7'h7F) begin
				zeros_q <= zeros_q + 7'h01;
			end
			hist_q <= {hist_q[6:0], pulse};
		end
	end
	// Violation pulses of substitution patterns decode back to zeros; B pulses stay ones
	wire bit1 = pulse && !(useCode && (b8zsSub || hdb3Sub) && sameAsLast);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dataValid <= 1'b0;
			dataOut <= 1'b0;
			bipolarViolation <= 1'b0;
			codeViolation <= 1'b0;
			excessiveZero <= 1'b0;
		end else begin
			dataValid <= decSym.valid;
			dataOut <= decSym.valid && bit1;
			bipolarViolation <= bipolar_violation;
			codeViolation <= cv;
			excessiveZero <= excessive_zero;
		end
	end
	// ============================================================
	// Zero-run counter and reporting
	logic [15:0] cnt_q;
	logic trfPrev_q;
	logic [PHASE_W+4:0] secCnt_q;
	wire countOn = zero_run_count_sel == rjd_pkg::COUNT_SEL_ON;
	wire cntInc = countOn && excessive_zero;
	wire secTick = secCnt_q == (PHASE_W+5)'(SECOND_CYC - 1);
	wire xfer = count_report_mode ? secTick : (count_transfer_trigger && !trfPrev_q);
	wire cntOvf = cntInc && cnt_q == 16'hFFFF && !xfer;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 16'h0000;
			trfPrev_q <= 1'b0;
			secCnt_q <= '0;
			cntL_q <= 8'h00;
			cntH_q <= 8'h00;
		end else begin
			trfPrev_q <= count_transfer_trigger;
			secCnt_q <= secTick ? '0 : secCnt_q + 1'b1;
			if (xfer) begin
				cntL_q <= cnt_q[7:0];
				cntH_q <= cnt_q[15:8];
				cnt_q <= {15'h0000, cntInc};
			end else if (cntInc) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
	// ============================================================
	// Pointer measurement
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) meas_q <= 8'h00;
		else if (!pointer_measure_mode) meas_q <= {1'b0, curDist};
		else if (curDist > meas_q[6:0]) meas_q <= {1'b0, curDist};
	end
	// ============================================================
	// Status flags: write one to clear, a new event wins over the clear
	wire [3:0] evt = {cntOvf, excessive_zero, bipolar_violation || cv, overflow || underflow};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) istat_q <= 8'h00;
		else istat_q <= {4'h0, evt | (istat_q[3:0] & ~(wrStat ? regWdata[3:0] : 4'h0))};
	end
	assign int_n = !(|(istat_q[3:0] & ien_q[3:0]));
	// ============================================================
	// Checks
	slip_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
		(istat_q[rjd_pkg::ST_SLIP] && ien_q[rjd_pkg::ST_SLIP]) |-> !int_n) else $error("slip irq missing");
	flag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
		(bipolar_violation || cv) |=> istat_q[rjd_pkg::ST_VIOL]) else $error("violation flag not set");
	zero_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
		excessive_zero |=> istat_q[rjd_pkg::ST_ZERO] && excessiveZero) else $error("zero flag not set");
	irq_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
		((istat_q[3:0] & ien_q[3:0]) == 4'h0) |-> int_n) else $error("irq without cause");
	xfer_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		(xfer && !cntInc) |=> cnt_q == 16'h0000 && {cntH_q, cntL_q} == $past(cnt_q)) else $error("bad transfer");
	count_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!countOn && !xfer) |=> cnt_q == $past(cnt_q)) else $error("counted while off");
	meas_live_a: assert property (@(posedge clk) disable iff (!reset_n)
		!pointer_measure_mode |=> meas_q[6:0] == $past(curDist)) else $error("live measure wrong");
	meas_peak_a: assert property (@(posedge clk) disable iff (!reset_n)
		pointer_measure_mode && !wrCfg |=> meas_q[6:0] >= $past(meas_q[6:0])) else $error("peak dropped");
	bypass_path_a: assert property (@(posedge clk) disable iff (!reset_n)
		!atten_enable |-> decSym.valid == inSym.valid) else $error("bypass broken");
	fill_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
		fill_q <= depth || wrCfg || $past(wrCfg)) else $error("fifo over depth");
	slip_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
		(overflow || underflow) |=> istat_q[rjd_pkg::ST_SLIP]) else $error("slip flag not set");
	ovf_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
		cntOvf |=> istat_q[rjd_pkg::ST_OVF]) else $error("overflow flag not set");
	count_step_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cntInc && !xfer && cnt_q != 16'hFFFF) |=> cnt_q == $past(cnt_q) + 16'h0001) else $error("count missed");
endmodule

// ==== tb/rjd_line_src.sv ====
`timescale 1ns/1ps
// ==========================================
// Recovered-symbol source standing in for clock and data recovery
module rjd_line_src (
	input wire logic clk,
	output logic lineSymValid,
	output logic linePos,
	output logic lineNeg
);
	initial begin
		lineSymValid = 1'h0;
		linePos = 1'h1;
		lineNeg = 1'h1;
	end
	// Symbol held well around the strobe, then inverted so stale levels are never trusted
	task automatic send(input logic p, input logic n);
		@(posedge clk);
		linePos <= p;
		lineNeg <= n;
		repeat (2) @(posedge clk);
		lineSymValid <= 1'h1;
		repeat (5) @(posedge clk);
		lineSymValid <= 1'h0;
		repeat (2) @(posedge clk);
		linePos <= ~p;
		lineNeg <= ~n;
	endtask
endmodule

// ==== tb/rjd_tb.sv ====
`timescale 1ns/1ps
module tb;
	// ==========================================
	// Signals and counters
	localparam int SEC_CYC = 200;
	localparam int LIMIT_CYC = 60000;
	logic clk, reset_n, regWr, regRd, lineSymValid, linePos, lineNeg, pol, lastData;
	logic [7:0] regAddr, regWdata, regRdata, rd;
	logic dataValid, dataOut, bipolarViolation, codeViolation, excessiveZero, int_n;
	int fails = 0;
	int samples_checked = 0;
	int nBpv = 0;
	int nCv = 0;
	int nExz = 0;
	int nData = 0;
	int cycles = 0;
	int base;
	logic [7:0] lcTab [4] = '{8'h00, 8'h04, 8'h02, 8'h03};
	int limTab [4] = '{rjd_pkg::ZR_AMI_ANSI, rjd_pkg::ZR_AMI_FCC, rjd_pkg::ZR_B8ZS, rjd_pkg::ZR_HDB3};
	rjd_decoder #(.SECOND_CYC(SEC_CYC)) dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.lineSymValid(lineSymValid), .linePos(linePos), .lineNeg(lineNeg), .dataValid(dataValid),
		.dataOut(dataOut), .bipolarViolation(bipolarViolation), .codeViolation(codeViolation),
		.excessiveZero(excessiveZero), .int_n(int_n));
	rjd_line_src src (.clk(clk), .lineSymValid(lineSymValid), .linePos(linePos), .lineNeg(lineNeg));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// ==========================================
	// Event monitor and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (bipolarViolation === 1'h1) nBpv <= nBpv + 1;
		if (codeViolation === 1'h1) nCv <= nCv + 1;
		if (excessiveZero === 1'h1) nExz <= nExz + 1;
		if (dataValid === 1'h1) begin
			nData <= nData + 1;
			lastData <= dataOut;
		end
		if (cycles == LIMIT_CYC) begin
			fails++;
			report_and_stop();
		end
	end
	// ==========================================
	// Compare, bus and symbol tasks
	task automatic check_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic check_cnt(input int got, input int exp, input string what);
		samples_checked++;
		if (got != exp) begin
			fails++;
			$display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'h0;
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'h0;
		#1 check_reg(regRdata, exp, what);
	endtask
	task automatic check_int(input logic e);
		repeat (2) @(posedge clk);
		#1 check_reg({7'h00, int_n}, {7'h00, e}, "int_n");
	endtask
	// Settling gap after each symbol so counters are final before compares
	task automatic sym(input logic p, input logic n);
		src.send(p, n);
		repeat (4) @(posedge clk);
	endtask
	task automatic mark();
		pol = ~pol;
		sym(pol, ~pol);
	endtask
	task automatic zeros(input int k);
		repeat (k) sym(1'h0, 1'h0);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		reset_n = 1'h0;
		regWr = 1'h0;
		regRd = 1'h0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		pol = 1'h0;
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		check_int(1'h1);
		expect_reg(rjd_pkg::ADDR_CFG, rjd_pkg::CFG_RESET, "cfg reset");
		expect_reg(rjd_pkg::ADDR_IEN, rjd_pkg::IEN_RESET, "enable reset");
		expect_reg(rjd_pkg::ADDR_LCODE, rjd_pkg::LCODE_RESET, "line code reset");
		reg_wr(8'h00, 8'hFF);
		expect_reg(8'h00, 8'h00, "unmapped");
		reg_wr(rjd_pkg::ADDR_CFG, 8'h3F);
		expect_reg(rjd_pkg::ADDR_CFG, 8'h3F, "cfg readback");
		reg_wr(rjd_pkg::ADDR_CFG, 8'h00);
		reg_wr(rjd_pkg::ADDR_ISTAT, 8'hFF);
		$display("test registers done");
		base = nData;
		mark();
		check_cnt(nData, base + 1, "bypass data");
		check_reg({7'h00, lastData}, 8'h01, "mark bit");
		zeros(1);
		check_reg({7'h00, lastData}, 8'h00, "space bit");
		base = nBpv;
		sym(pol, ~pol);
		check_cnt(nBpv, base + 1, "bipolar violation");
		expect_reg(rjd_pkg::ADDR_ISTAT, 8'h02, "violation flag");
		check_int(1'h1);
		reg_wr(rjd_pkg::ADDR_IEN, 8'h02);
		check_int(1'h0);
		reg_wr(rjd_pkg::ADDR_ISTAT, 8'h02);
		check_int(1'h1);
		reg_wr(rjd_pkg::ADDR_IEN, 8'h00);
		$display("test ami done");
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h02);
		mark();
		base = nCv;
		zeros(3);
		sym(pol, ~pol);
		sym(~pol, pol);
		zeros(1);
		sym(~pol, pol);
		sym(pol, ~pol);
		check_cnt(nCv, base, "valid substitution");
		mark();
		sym(pol, ~pol);
		check_cnt(nCv, base + 1, "code violation");
		$display("test b8zs done");
		reg_wr(rjd_pkg::ADDR_ISTAT, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			reg_wr(rjd_pkg::ADDR_LCODE, lcTab[i]);
			mark();
			base = nExz;
			zeros(limTab[i]);
			check_cnt(nExz, base, "zero run at limit");
			zeros(1);
			check_cnt(nExz, base + 1, "zero run over limit");
		end
		expect_reg(rjd_pkg::ADDR_ISTAT, 8'h04, "zero run flag");
		$display("test zero runs done");
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h0B);
		repeat (3) begin
			mark();
			zeros(4);
		end
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h4B);
		expect_reg(rjd_pkg::ADDR_CNTL, 8'h03, "count low");
		expect_reg(rjd_pkg::ADDR_CNTH, 8'h00, "count high");
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h0B);
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h4B);
		expect_reg(rjd_pkg::ADDR_CNTL, 8'h00, "count cleared");
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h03);
		mark();
		zeros(4);
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h43);
		expect_reg(rjd_pkg::ADDR_CNTL, 8'h00, "count disabled");
		$display("test manual count done");
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h2B);
		mark();
		zeros(4);
		rd = 8'h00;
		for (int k = 0; k < SEC_CYC && rd !== 8'h01; k++) begin
			@(posedge clk);
			regRd <= 1'h1;
			regAddr <= rjd_pkg::ADDR_CNTL;
			@(posedge clk);
			regRd <= 1'h0;
			#1 rd = regRdata;
		end
		check_reg(rd, 8'h01, "auto report");
		repeat (2 * SEC_CYC + 10) @(posedge clk);
		expect_reg(rjd_pkg::ADDR_CNTL, 8'h00, "auto cleared");
		$display("test auto count done");
		reg_wr(rjd_pkg::ADDR_LCODE, 8'h00);
		reg_wr(rjd_pkg::ADDR_CFG, 8'h01);
		base = nData;
		repeat (15) mark();
		check_cnt(nData, base, "held in fifo");
		repeat (12) mark();
		check_cnt(int'(nData > base), 1, "fifo output");
		$display("test attenuator done");
		report_and_stop();
	end
endmodule
